// ===== hw/apc_pkg.sv
// Constants, field layouts and the control carrier for the playback control register bank.
// Assumes a single 200 MHz clock domain and an Avalon-MM register port with waitrequest.
`default_nettype none
package apc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_FIRST = 6'h06, IDX_LAST = 6'h20;
  localparam logic [5:0] IDX_TIMER = 6'h06, IDX_ALC_A = 6'h07, IDX_ALC_REF = 6'h08;
  localparam logic [5:0] IDX_ALC_VOL_L = 6'h09, IDX_OUT_VOL_L = 6'h0A, IDX_ALC_C = 6'h0B;
  localparam logic [5:0] IDX_ALC_VOL_R = 6'h0C, IDX_OUT_VOL_R = 6'h0D, IDX_PLAY = 6'h0E;
  localparam logic [5:0] IDX_HP = 6'h0F, IDX_INSEL = 6'h10, IDX_FILT = 6'h11;
  localparam logic [5:0] IDX_SEP_A_LO = 6'h12, IDX_SEP_A_HI = 6'h13;
  localparam logic [5:0] IDX_SEP_B_LO = 6'h14, IDX_SEP_B_HI = 6'h15;
  localparam logic [5:0] IDX_EQ_A_LO = 6'h16, IDX_EQ_A_HI = 6'h17, IDX_EQ_B_LO = 6'h18;
  localparam logic [5:0] IDX_EQ_B_HI = 6'h19, IDX_EQ_C_LO = 6'h1A, IDX_EQ_C_HI = 6'h1B;
  localparam logic [5:0] IDX_WIND_A_LO = 6'h1C, IDX_WIND_A_HI = 6'h1D;
  localparam logic [5:0] IDX_WIND_B_LO = 6'h1E, IDX_WIND_B_HI = 6'h1F, IDX_MIX_PWR = 6'h20;

  // ****************************************************************
  // Bit positions
  // ****************************************************************
  localparam int TS_RAMP = 7, TS_WAIT2 = 6, TS_ZTM1 = 5, TS_ZTM0 = 4;
  localparam int TS_WAIT1 = 3, TS_WAIT0 = 2, TS_FAST1 = 1, TS_FAST0 = 0;
  localparam int AA_ENABLE = 5, AA_ZC_DIS = 4, AA_ATT1 = 3, AA_ATT0 = 2;
  localparam int AA_RGAIN0 = 1, AA_LMTH0 = 0;
  localparam int AC_RGAIN1 = 7, AC_LMTH1 = 6, AC_HP_COM = 1;
  localparam int PM_LOOP = 6, PM_SOFT_MUTE_CTRL = 5, PM_OLINK = 4, PM_BST1 = 3, PM_BST0 = 2;
  localparam int PM_DEM1 = 1, PM_DEM0 = 0;
  localparam int HP_ALINK = 3, HP_MONO = 2, HP_MIN = 1, HP_DAC = 0;
  localparam int FS_GN1 = 7, FS_GN0 = 6, FS_WIND = 4, FS_EQ = 3, FS_SEP = 2;
  localparam int COEF_TYPE = 7;

  // ****************************************************************
  // Timing, widths and bus answers
  // ****************************************************************
  localparam int RAMP_W = 11;
  localparam logic [RAMP_W-1:0] VOL_RAMP_SLOW = 11'h425;  // 1061 sample periods.
  localparam logic [RAMP_W-1:0] VOL_RAMP_FAST = 11'h100;  // 256 sample periods.
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_REF = 8'hE1, RST_OVOL = 8'h18, RST_PLAY = 8'h11;
  localparam logic [7:0] RST_HP = 8'h08, RST_DEM = 8'h00;
  localparam logic [1:0] DEM_OFF = 2'h1;

  // Writable bits of each register; all other bits store and read as zero.
  function automatic logic [7:0] reg_mask(input logic [5:0] idx);
    unique case (idx)
      IDX_ALC_A, IDX_SEP_B_HI, IDX_EQ_B_HI, IDX_WIND_B_HI, IDX_MIX_PWR: reg_mask = 8'h3F;
      IDX_ALC_C:                                 reg_mask = 8'hC2;
      IDX_PLAY:                                  reg_mask = 8'h7F;
      IDX_HP:                                    reg_mask = 8'h0F;
      IDX_INSEL:                                 reg_mask = 8'hFE;
      IDX_FILT:                                  reg_mask = 8'hDC;
      IDX_SEP_A_HI, IDX_WIND_A_HI:               reg_mask = 8'hBF;
      default:                                   reg_mask = 8'hFF;
    endcase
  endfunction

  // Default value of each register.
  function automatic logic [7:0] reg_reset(input logic [5:0] idx);
    unique case (idx)
      IDX_ALC_REF, IDX_ALC_VOL_L, IDX_ALC_VOL_R: reg_reset = RST_REF;
      IDX_OUT_VOL_L, IDX_OUT_VOL_R:              reg_reset = RST_OVOL;
      IDX_PLAY:                                  reg_reset = RST_PLAY;
      IDX_HP:                                    reg_reset = RST_HP;
      default:                                   reg_reset = RST_DEM;
    endcase
  endfunction

  // ****************************************************************
  // Decoded controls delivered to the playback datapath
  // ****************************************************************
  typedef struct packed {
    logic [RAMP_W-1:0] volume_ramp_samples;
    logic [2:0]  alc_recovery_wait_sel;
    logic [1:0]  alc_zero_cross_timeout_sel;
    logic [1:0]  alc_fast_recovery_sel;
    logic        level_control_enable;
    logic        limiter_zero_cross_enable;
    logic [1:0]  limiter_atten_step;
    logic [1:0]  recovery_gain_step;
    logic [1:0]  limiter_threshold_sel;
    logic [7:0]  recovery_reference_level;
    logic [7:0]  left_alc_volume_code;
    logic [7:0]  right_alc_volume_code;
    logic [7:0]  left_output_volume_code;
    logic [7:0]  right_output_volume_code;
    logic        hp_common_high;
    logic        soft_mute_ctrl;
    logic        dac_source_loopback;
    logic [1:0]  bass_boost_sel;
    logic [1:0]  deemphasis_sel;
    logic        headphone_mono_sel;
    logic        mono_in_to_headphone_switch;
    logic        dac_to_headphone_switch;
    logic [7:0]  input_select_power;
    logic [1:0]  gain_block_sel;
    logic        separation_filter_enable;
    logic        separation_filter_mute;
    logic        separation_filter_type;
    logic [13:0] separation_coef_a;
    logic [13:0] separation_coef_b;
    logic        equalizer_enable;
    logic [15:0] equalizer_coef_a;
    logic [13:0] equalizer_coef_b;
    logic [15:0] equalizer_coef_c;
    logic        wind_filter_enable;
    logic        wind_filter_type;
    logic [13:0] wind_coef_a;
    logic [13:0] wind_coef_b;
    logic [7:0]  mixer_input_power;
  } apc_ctrl_type;

  localparam apc_ctrl_type CTRL_DEFAULT = '{
    volume_ramp_samples:       VOL_RAMP_SLOW,
    limiter_zero_cross_enable: 1'b1,
    recovery_reference_level:  RST_REF,
    left_alc_volume_code:      RST_REF,
    right_alc_volume_code:     RST_REF,
    left_output_volume_code:   RST_OVOL,
    right_output_volume_code:  RST_OVOL,
    deemphasis_sel:            DEM_OFF,
    separation_filter_mute:    1'b1,
    default:                   '0
  };

endpackage
`default_nettype wire

// ===== hw/apc_regs.sv
// Playback control register bank: LEVEL_CONTROL_ENABLE, volume, mute, loopback, filter settings.
// Assumes an Avalon-MM master on ref_clk_i and an asynchronous power-down pin.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module apc_regs
(
  // Clock and reset.
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  // Power-down pin, active low.
  input  wire logic                 power_down_pin_n_i,
  // Avalon-MM slave.
  input  wire logic [7:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output var  logic [31:0]          avs_readdata_o,
  output var  logic [1:0]           avs_response_o,
  output var  logic                 avs_waitrequest_o,
  // Decoded controls.
  output var  apc_pkg::apc_ctrl_type ctrl_o
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic pd_n_s;

  apc_sync2 #(.RESET_VAL(1'b0)) u_pd_sync
  (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (power_down_pin_n_i),
    .sync_o    (pd_n_s)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [7:0]            regs [apc_pkg::IDX_FIRST:apc_pkg::IDX_LAST];
  wire  [5:0]            idx  = avs_address_i[7:2];
  wire                   req  = avs_read_i | avs_write_i;
  wire                   ack  = ~avs_waitrequest_o;
  wire                   hit  = (avs_address_i[1:0] == 2'h0) && (idx >= apc_pkg::IDX_FIRST)
                                && (idx <= apc_pkg::IDX_LAST);
  wire                   next_ack = req & ~ack;
  // Write lands at the edge where the master sees waitrequest low; unused bits are dropped.
  wire                   wr_commit = avs_write_i & ack & hit & avs_byteenable_i[0] & pd_n_s;
  wire  [7:0]            wr_byte   = avs_writedata_i[7:0] & apc_pkg::reg_mask(idx);
  wire  [7:0]            rd_byte   = hit ? regs[idx] : 8'h00;

  // The answer comes one cycle after the request; waitrequest rests high between requests.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      avs_response_o    <= apc_pkg::RESP_OKAY;
    end
    else
    begin
      avs_waitrequest_o <= ~next_ack;
      if (next_ack)
      begin
        avs_readdata_o <= {24'h00_0000, avs_read_i ? rd_byte : 8'h00};
        avs_response_o <= hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  // Each register reloads its default while the pin holds power-down, so a
  // write during power-down is lost rather than half-applied.
  generate
    for (genvar g = apc_pkg::IDX_FIRST; g <= apc_pkg::IDX_LAST; g++)
    begin : g_reg
      localparam logic [5:0] GIDX = 6'(g);
      always_ff @(posedge ref_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          regs[g] <= apc_pkg::reg_reset(GIDX);
        else if (!pd_n_s)
          regs[g] <= apc_pkg::reg_reset(GIDX);
        else if (wr_commit && (idx == GIDX))
          regs[g] <= wr_byte;
      end
    end
  endgenerate

  // ****************************************************************
  // Control decode
  // ****************************************************************
  apc_pkg::apc_ctrl_type next_ctrl;
  wire [7:0] r_ts  = regs[apc_pkg::IDX_TIMER];
  wire [7:0] r_aa  = regs[apc_pkg::IDX_ALC_A];
  wire [7:0] r_ac  = regs[apc_pkg::IDX_ALC_C];
  wire [7:0] r_pm  = regs[apc_pkg::IDX_PLAY];
  wire [7:0] r_hp  = regs[apc_pkg::IDX_HP];
  wire [7:0] r_fs  = regs[apc_pkg::IDX_FILT];
  wire       olink = r_pm[apc_pkg::PM_OLINK];
  wire       alink = r_hp[apc_pkg::HP_ALINK];

  // Timer fields; the wait field is split over bit 6 and the adjacent bits 3:2.
  assign next_ctrl.volume_ramp_samples = r_ts[apc_pkg::TS_RAMP] ? apc_pkg::VOL_RAMP_FAST
                                         : apc_pkg::VOL_RAMP_SLOW;
  assign next_ctrl.alc_recovery_wait_sel = {r_ts[apc_pkg::TS_WAIT2], r_ts[apc_pkg::TS_WAIT1],
                                            r_ts[apc_pkg::TS_WAIT0]};
  assign next_ctrl.alc_zero_cross_timeout_sel = {r_ts[apc_pkg::TS_ZTM1],
                                                 r_ts[apc_pkg::TS_ZTM0]};
  assign next_ctrl.alc_fast_recovery_sel = {r_ts[apc_pkg::TS_FAST1],
                                            r_ts[apc_pkg::TS_FAST0]};

  // Level control; two fields take their upper bit from the third LEVEL_CONTROL_ENABLE register.
  assign next_ctrl.level_control_enable = r_aa[apc_pkg::AA_ENABLE];
  assign next_ctrl.limiter_zero_cross_enable = ~r_aa[apc_pkg::AA_ZC_DIS];
  assign next_ctrl.limiter_atten_step = {r_aa[apc_pkg::AA_ATT1], r_aa[apc_pkg::AA_ATT0]};
  assign next_ctrl.recovery_gain_step = {r_ac[apc_pkg::AC_RGAIN1],
                                         r_aa[apc_pkg::AA_RGAIN0]};
  assign next_ctrl.limiter_threshold_sel = {r_ac[apc_pkg::AC_LMTH1],
                                            r_aa[apc_pkg::AA_LMTH0]};
  assign next_ctrl.recovery_reference_level = regs[apc_pkg::IDX_ALC_REF];
  assign next_ctrl.hp_common_high = r_ac[apc_pkg::AC_HP_COM];

  // Linked volumes steer the right channel from the left field; the stored right
  // field keeps its value so unlinking restores the old right level.
  assign next_ctrl.left_alc_volume_code  = regs[apc_pkg::IDX_ALC_VOL_L];
  assign next_ctrl.right_alc_volume_code = alink ? regs[apc_pkg::IDX_ALC_VOL_L]
                                           : regs[apc_pkg::IDX_ALC_VOL_R];
  assign next_ctrl.left_output_volume_code  = regs[apc_pkg::IDX_OUT_VOL_L];
  assign next_ctrl.right_output_volume_code = olink ? regs[apc_pkg::IDX_OUT_VOL_L]
                                              : regs[apc_pkg::IDX_OUT_VOL_R];

  // Playback mode and headphone routing.
  assign next_ctrl.soft_mute_ctrl = r_pm[apc_pkg::PM_SOFT_MUTE_CTRL];
  assign next_ctrl.dac_source_loopback = r_pm[apc_pkg::PM_LOOP];
  assign next_ctrl.bass_boost_sel = {r_pm[apc_pkg::PM_BST1], r_pm[apc_pkg::PM_BST0]};
  assign next_ctrl.deemphasis_sel = {r_pm[apc_pkg::PM_DEM1], r_pm[apc_pkg::PM_DEM0]};
  assign next_ctrl.headphone_mono_sel = r_hp[apc_pkg::HP_MONO];
  assign next_ctrl.mono_in_to_headphone_switch = r_hp[apc_pkg::HP_MIN];
  assign next_ctrl.dac_to_headphone_switch = r_hp[apc_pkg::HP_DAC];
  assign next_ctrl.input_select_power = regs[apc_pkg::IDX_INSEL];
  assign next_ctrl.mixer_input_power = regs[apc_pkg::IDX_MIX_PWR];

  // Filter stages; a disabled separation stage is muted, the others pass through.
  assign next_ctrl.gain_block_sel = {r_fs[apc_pkg::FS_GN1], r_fs[apc_pkg::FS_GN0]};
  assign next_ctrl.separation_filter_enable = r_fs[apc_pkg::FS_SEP];
  assign next_ctrl.separation_filter_mute = ~r_fs[apc_pkg::FS_SEP];
  assign next_ctrl.equalizer_enable = r_fs[apc_pkg::FS_EQ];
  assign next_ctrl.wind_filter_enable = r_fs[apc_pkg::FS_WIND];
  assign next_ctrl.separation_filter_type = regs[apc_pkg::IDX_SEP_A_HI][apc_pkg::COEF_TYPE];
  assign next_ctrl.wind_filter_type = regs[apc_pkg::IDX_WIND_A_HI][apc_pkg::COEF_TYPE];

  // Coefficients assembled from low and high byte registers.
  assign next_ctrl.separation_coef_a = {regs[apc_pkg::IDX_SEP_A_HI][5:0],
                                        regs[apc_pkg::IDX_SEP_A_LO]};
  assign next_ctrl.separation_coef_b = {regs[apc_pkg::IDX_SEP_B_HI][5:0],
                                        regs[apc_pkg::IDX_SEP_B_LO]};
  assign next_ctrl.equalizer_coef_a = {regs[apc_pkg::IDX_EQ_A_HI],
                                       regs[apc_pkg::IDX_EQ_A_LO]};
  assign next_ctrl.equalizer_coef_b = {regs[apc_pkg::IDX_EQ_B_HI][5:0],
                                       regs[apc_pkg::IDX_EQ_B_LO]};
  assign next_ctrl.equalizer_coef_c = {regs[apc_pkg::IDX_EQ_C_HI],
                                       regs[apc_pkg::IDX_EQ_C_LO]};
  assign next_ctrl.wind_coef_a = {regs[apc_pkg::IDX_WIND_A_HI][5:0],
                                  regs[apc_pkg::IDX_WIND_A_LO]};
  assign next_ctrl.wind_coef_b = {regs[apc_pkg::IDX_WIND_B_HI][5:0],
                                  regs[apc_pkg::IDX_WIND_B_LO]};

  // Registered controls cost one cycle of latency but keep the outputs glitch free.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_o <= apc_pkg::CTRL_DEFAULT;
    else
      ctrl_o <= next_ctrl;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  ack_single_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low for two cycles");

  req_answer_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o) else $error("request not answered");

  unmapped_err_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (req && avs_waitrequest_o && !hit) |=> (avs_response_o == apc_pkg::RESP_SLVERR)
                                           && (avs_readdata_o == 32'h0000_0000))
    else $error("unmapped access not flagged");

  read_upper_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (avs_read_i && avs_waitrequest_o && hit) |=> avs_readdata_o[31:8] == 24'h00_0000
    && ((avs_readdata_o[7:0] & ~apc_pkg::reg_mask($past(idx))) == 8'h00))
    else $error("read returned unused bits");

  write_mask_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (wr_commit && idx == apc_pkg::IDX_PLAY) |=> regs[apc_pkg::IDX_PLAY]
    == ($past(avs_writedata_i[7:0]) & apc_pkg::reg_mask(apc_pkg::IDX_PLAY)))
    else $error("write not stored with mask");

  pd_default_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (!pd_n_s) [*2] |=> ctrl_o == apc_pkg::CTRL_DEFAULT)
    else $error("power-down did not restore defaults");

  ovol_link_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    olink |=> ctrl_o.right_output_volume_code == $past(regs[apc_pkg::IDX_OUT_VOL_L]))
    else $error("linked right output volume wrong");

  avol_link_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !alink |=> ctrl_o.right_alc_volume_code == $past(regs[apc_pkg::IDX_ALC_VOL_R]))
    else $error("independent right LEVEL_CONTROL_ENABLE volume wrong");

  ramp_sel_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    r_ts[apc_pkg::TS_RAMP] |=> ctrl_o.volume_ramp_samples == apc_pkg::VOL_RAMP_FAST)
    else $error("ramp length not fast");

  zero_cross_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ##1 ctrl_o.limiter_zero_cross_enable != $past(r_aa[apc_pkg::AA_ZC_DIS]))
    else $error("zero-cross enable inverted");

  sep_mute_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ctrl_o.separation_filter_mute != ctrl_o.separation_filter_enable)
    else $error("separation mute and enable agree");

  write_cov: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) wr_commit);
  read_cov: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
    avs_read_i && ack && hit);
  unlink_cov: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) !olink && !alink);
  pd_cov: cover property (@(posedge ref_clk_i) disable iff (!nrst_i) $fell(pd_n_s));

endmodule
`default_nettype wire

// ===== hw/apc_sync2.sv
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the destination clock is the block clock; reset value is a constant parameter.
`timescale 1ns/10ps
`default_nettype none
module apc_sync2
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Level in and out.
  input  wire logic async_i,
  output var  logic sync_o
);

  logic meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== tb/apc_regs_tb.sv
// Self-checking bench for the playback control register bank.
// Assumes apc_regs on a 200 MHz clock; the bench is the Avalon-MM master.
`timescale 1ns/10ps
`default_nettype none
module apc_regs_tb;
  // Tables per register index 06h..20h: default value and readable bits.
  localparam logic [7:0] RST_TAB [0:26] = '{8'h00, 8'h00, 8'hE1, 8'hE1, 8'h18, 8'h00, 8'hE1,
    8'h18, 8'h11, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK_TAB [0:26] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hC2, 8'hFF,
    8'hFF, 8'h7F, 8'h0F, 8'hFE, 8'hDC, 8'hFF, 8'hBF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
    8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'h3F, 8'h3F};
  logic                  ref_clk_i, nrst_i, power_down_pin_n_i, avs_read_i, avs_write_i;
  logic [7:0]            avs_address_i;
  logic [31:0]           avs_writedata_i, avs_readdata_o, rd_q;
  logic [3:0]            avs_byteenable_i;
  logic [1:0]            avs_response_o, rs_q;
  logic                  avs_waitrequest_o;
  apc_pkg::apc_ctrl_type ctrl_o;
  int                    n_mismatch, total_checks;
  apc_regs u_apc_regs (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .power_down_pin_n_i(power_down_pin_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o), .ctrl_o(ctrl_o));
  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(posedge ref_clk_i);
    avs_address_i <= addr;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, wd};
    @(posedge ref_clk_i iff avs_waitrequest_o === 1'b0);
    rd_q = avs_readdata_o;
    rs_q = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read and compare data and response; settle lets ctrl_o follow a write.
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input logic [1:0] rexp);
    bus(1'b0, addr, 8'h00);
    chk(rd_q, {24'h0, exp});
    chk(32'(rs_q), 32'(rexp));
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    finish_test();
  end
  // Main sequence.
  initial
  begin
    {nrst_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {n_mismatch, total_checks} = '0;
    power_down_pin_n_i = 1'b1;
    avs_byteenable_i = 4'hF;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 6; i <= 32; i++) rdchk(8'(i * 4), RST_TAB[i - 6], 2'h0);
    chk({ctrl_o.volume_ramp_samples, ctrl_o.limiter_zero_cross_enable, ctrl_o.deemphasis_sel,
      ctrl_o.separation_filter_mute, ctrl_o.bass_boost_sel}, {11'h425, 1'b1, 2'h1, 1'b1, 2'h0});
    // Unmapped and misaligned addresses answer with an error and no data.
    rdchk(8'h14, 8'h00, 2'h2);
    bus(1'b1, 8'h84, 8'hFF);
    rdchk(8'h84, 8'h00, 2'h2);
    rdchk(8'h19, 8'h00, 2'h2);
    // All ones everywhere: unused bits must read back as zero.
    for (int i = 6; i <= 32; i++) bus(1'b1, 8'(i * 4), 8'hFF);
    for (int i = 6; i <= 32; i++) rdchk(8'(i * 4), MSK_TAB[i - 6], 2'h0);
    chk({ctrl_o.volume_ramp_samples, ctrl_o.limiter_zero_cross_enable, ctrl_o.soft_mute_ctrl,
      ctrl_o.dac_source_loopback, ctrl_o.headphone_mono_sel, ctrl_o.separation_filter_mute},
      {11'h100, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0});
    chk({ctrl_o.separation_filter_enable, ctrl_o.equalizer_enable, ctrl_o.wind_filter_enable,
      ctrl_o.separation_filter_type, ctrl_o.wind_filter_type, ctrl_o.equalizer_coef_b},
      {5'h1F, 14'h3FFF});
    chk({ctrl_o.limiter_threshold_sel, ctrl_o.recovery_gain_step, ctrl_o.alc_recovery_wait_sel,
      ctrl_o.alc_zero_cross_timeout_sel, ctrl_o.alc_fast_recovery_sel}, 32'h07FF);
    chk({ctrl_o.level_control_enable, ctrl_o.hp_common_high, ctrl_o.gain_block_sel,
      ctrl_o.mono_in_to_headphone_switch, ctrl_o.dac_to_headphone_switch,
      ctrl_o.limiter_atten_step, ctrl_o.bass_boost_sel, ctrl_o.deemphasis_sel}, 32'h0FFF);
    chk({ctrl_o.input_select_power, ctrl_o.mixer_input_power}, 32'hFE3F);
    chk({ctrl_o.separation_coef_a, ctrl_o.wind_coef_b}, 32'h0FFF_FFFF);
    chk({ctrl_o.equalizer_coef_c, ctrl_o.left_output_volume_code, ctrl_o.left_alc_volume_code},
      32'hFFFF_FFFF);
    // A coefficient low byte lands alone under the stored high byte.
    bus(1'b1, 8'h58, 8'h5A);
    settle();
    chk(32'(ctrl_o.equalizer_coef_a), 32'hFF5A);
    // Linked volumes: the left field drives the right channel, the right register stays.
    bus(1'b1, 8'h28, 8'h40);
    bus(1'b1, 8'h34, 8'h80);
    bus(1'b1, 8'h24, 8'h21);
    bus(1'b1, 8'h30, 8'h42);
    settle();
    chk({ctrl_o.right_output_volume_code, ctrl_o.right_alc_volume_code}, 32'h4021);
    rdchk(8'h34, 8'h80, 2'h0);
    bus(1'b1, 8'h38, 8'h00);
    bus(1'b1, 8'h3C, 8'h00);
    settle();
    chk({ctrl_o.right_output_volume_code, ctrl_o.right_alc_volume_code}, 32'h8042);
    // A write without its low byte lane enabled is dropped.
    avs_byteenable_i <= 4'hE;
    bus(1'b1, 8'h28, 8'h77);
    avs_byteenable_i <= 4'hF;
    rdchk(8'h28, 8'h40, 2'h0);
    // Power-down pin low restores every default and blocks writes.
    power_down_pin_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    bus(1'b1, 8'h28, 8'h55);
    for (int i = 6; i <= 32; i++) rdchk(8'(i * 4), RST_TAB[i - 6], 2'h0);
    power_down_pin_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    finish_test();
  end
endmodule
`default_nettype wire
